// *** rtl/cls_sequencer.sv ***
// cls_sequencer: steps through channel list entries loaded over apb
// assumes conversion and list clocks arrive as async pins
`timescale 1ns/1ps
`default_nettype none
module cls_sequencer
  import cls_pkg::*;
#(
  parameter int unsigned LIST_DEPTH = 32,
  parameter int unsigned FIFO_DEPTH = 32,
  parameter int unsigned NUM_OUT    = 8,
  parameter logic        MULTI_SS   = 1'b1
) (
  input  wire logic               clk_i,
  input  wire logic               nrst_i,
  input  wire logic               ce_i,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               conversion_clock_i,
  input  wire logic               list_clock_i,
  input  wire logic [15:0]        sample_i,
  output logic                    step_irq_o,
  output logic                    sync_pulse_o,
  output logic                    differential_o,
  output logic      [7:0]         chan_o,
  output logic      [3:0]         gain_o,
  output logic                    dir_o,
  output logic      [1:0]         subsys_o,
  output logic      [NUM_OUT*16-1:0] out_o,
  output logic                    busy_o
);
  localparam int unsigned LAW = $clog2(LIST_DEPTH);
  // =========================================================
  // pin synchronisers and tick detection
  logic [1:0] cv_sync_ff;
  logic [1:0] cl_sync_ff;
  logic       cv_last_ff;
  logic       cl_last_ff;
  logic       cv_tick;
  logic       cl_tick;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cv_sync_ff <= '0;
      cl_sync_ff <= '0;
      cv_last_ff <= 1'b0;
      cl_last_ff <= 1'b0;
    end else if (ce_i) begin
      cv_sync_ff <= {cv_sync_ff[0], conversion_clock_i};
      cl_sync_ff <= {cl_sync_ff[0], list_clock_i};
      cv_last_ff <= cv_sync_ff[1];
      cl_last_ff <= cl_sync_ff[1];
    end
  end
  assign cv_tick = cv_sync_ff[1] && !cv_last_ff;
  assign cl_tick = cl_sync_ff[1] && !cl_last_ff;

  // =========================================================
  // apb registers
  logic [31:0]    list_ff [LIST_DEPTH];
  logic [LAW-1:0] wr_idx_ff;
  logic [LAW-1:0] rd_idx_ff;
  logic [15:0]    settle_ff;
  logic [31:0]    ts_ff;
  logic           start_pulse_ff;
  logic [15:0]    outval_ff;
  logic           apb_wr;
  logic           apb_rd;
  logic           apb_hit;
  logic           fifo_out_valid;
  logic [31:0]    fifo_out_data;
  logic           fifo_in_ready;
  logic           irq_ff;
  cls_state_e     state_ff;

  assign apb_wr  = ce_i && psel && penable && pwrite;
  assign apb_rd  = ce_i && psel && penable && !pwrite;
  assign apb_hit = paddr inside {OFS_CTRL, OFS_STATUS, OFS_ENTRY,
                   OFS_SETTLE, OFS_DATA, OFS_TSTAMP, OFS_OUTVAL};

  always_ff @(posedge clk_i) begin
    if (apb_wr && paddr == OFS_ENTRY) begin
      list_ff[wr_idx_ff] <= pwdata;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_idx_ff      <= '0;
      settle_ff      <= SETTLE_RST;
      start_pulse_ff <= 1'b0;
      outval_ff      <= '0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      prdata         <= '0;
    end else if (ce_i) begin
      start_pulse_ff <= 1'b0;
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !apb_hit;
      if (apb_wr && pready) begin
        unique case (paddr)
          OFS_CTRL: begin
            start_pulse_ff <= pwdata[0];
            if (pwdata[1]) wr_idx_ff <= '0;
          end
          OFS_ENTRY:  wr_idx_ff <= wr_idx_ff + 1'b1;
          OFS_SETTLE: settle_ff <= pwdata[15:0];
          OFS_OUTVAL: outval_ff <= pwdata[15:0];
          default: ;
        endcase
      end
      if (psel && !penable) begin
        unique case (paddr)
          OFS_STATUS: prdata <= {25'h000_0000, 3'(state_ff),
                                 fifo_in_ready, fifo_out_valid,
                                 irq_ff, busy_o};
          OFS_SETTLE: prdata <= {16'h0000, settle_ff};
          OFS_DATA:   prdata <= fifo_out_data;
          OFS_TSTAMP: prdata <= ts_ff;
          OFS_ENTRY:  prdata <= {{(32-LAW){1'b0}}, wr_idx_ff};
          default:    prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // =========================================================
  // sequencer state machine
  cls_entry_s     ent;
  logic [31:0]    raw;
  logic [16:0]    cnt_ff;
  logic [1:0]     ts_cnt_ff;
  logic [31:0]    push_data;
  logic           push_valid;
  logic [NUM_OUT*16-1:0] hold_ff;
  logic [LAW-1:0] nxt_rd_idx;
  logic           nxt_slow;

  assign raw = list_ff[rd_idx_ff];
  // a no-wait step skips the fetch, so the next entry's slow flag
  // has to be looked up before the index moves
  assign nxt_rd_idx = rd_idx_ff + 1'b1;
  assign nxt_slow   = list_ff[nxt_rd_idx][BIT_SLOW];
  // bits 18..16 are never looked at
  assign ent = '{more: raw[BIT_MORE], dir: raw[BIT_DIR],
                 ss: raw[BIT_SS_LO+1:BIT_SS_LO], irq: raw[BIT_IRQ],
                 nowait: raw[BIT_NOWAIT], discard: raw[BIT_DISCARD],
                 listwait: raw[BIT_LISTWAIT], sync: raw[BIT_SYNC],
                 defer: raw[BIT_DEFER], commit: raw[BIT_COMMIT],
                 tstamp: raw[BIT_TSTAMP], slow: raw[BIT_SLOW],
                 diff: raw[BIT_DIFF],
                 gain: 4'((raw & GAIN_MASK) >> GAIN_LO),
                 chan: 8'(raw & CHAN_MASK)};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff  <= ST_IDLE;
      rd_idx_ff <= '0;
      cnt_ff    <= '0;
      ts_cnt_ff <= '0;
    end else if (ce_i) begin
      unique case (state_ff)
        ST_IDLE: if (start_pulse_ff) begin
          rd_idx_ff <= '0;
          state_ff  <= ST_FETCH;
        end
        ST_FETCH: state_ff <= ST_WAIT;
        ST_WAIT: begin
          // a list-clock wait step waits on the list tick alone, ignoring the conversion tick
          if (ent.listwait ? cl_tick : cv_tick) begin
            cnt_ff   <= ent.slow ? {settle_ff, 1'b0}
                                 : {1'b0, settle_ff};
            state_ff <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // counts down to one, so a step settles cnt_ff cycles
          if (cnt_ff > 17'h0_0001) cnt_ff <= cnt_ff - 1'b1;
          else state_ff <= ST_STORE;
        end
        ST_STORE: if (fifo_in_ready || ent.discard || ent.dir) begin
          ts_cnt_ff <= 2'(TS_WORDS);
          state_ff  <= ent.tstamp ? ST_TS : ST_DONE;
        end
        ST_TS: if (fifo_in_ready) begin
          ts_cnt_ff <= ts_cnt_ff - 1'b1;
          if (ts_cnt_ff == 2'd1) state_ff <= ST_DONE;
        end
        ST_DONE: begin
          rd_idx_ff <= nxt_rd_idx;
          if (!ent.more) state_ff <= ST_IDLE;
          else if (ent.nowait) state_ff <= ST_SETTLE;
          else state_ff <= ST_FETCH;
          cnt_ff <= nxt_slow ? {settle_ff, 1'b0}
                             : {1'b0, settle_ff};
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // =========================================================
  // timestamp counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) ts_ff <= '0;
    else if (ce_i) ts_ff <= ts_ff + 1'b1;
  end

  // =========================================================
  // input samples and timestamps; discard skips the sample push, not the timestamps
  assign push_valid = (state_ff == ST_STORE && !ent.dir
                       && !ent.discard)
                      || state_ff == ST_TS;
  assign push_data  = (state_ff == ST_TS) ? ts_ff
                      : {8'h00, ent.chan, sample_i};

  cls_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .en_i       (ce_i),
    .in_data_i  (push_data),
    .in_valid_i (push_valid),
    .in_ready_o (fifo_in_ready),
    .out_data_o (fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(apb_rd && pready && paddr == OFS_DATA)
  );

  // =========================================================
  // outputs: holding registers and step signals
  logic step_end;
  assign step_end = ce_i && state_ff == ST_DONE;
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      logic load_here;
      assign load_here = ent.dir && !ent.discard && ent.chan == 8'(g);
      always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          hold_ff[g*16 +: 16] <= '0;
          out_o[g*16 +: 16]   <= '0;
        end else if (step_end) begin
          if (load_here) begin
            hold_ff[g*16 +: 16] <= outval_ff;
          end
          // the committing step's own value goes out with the others
          if (ent.commit) begin
            out_o[g*16 +: 16] <= load_here ? outval_ff
                                           : hold_ff[g*16 +: 16];
          end else if (load_here && !ent.defer) begin
            out_o[g*16 +: 16] <= outval_ff;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ff         <= 1'b0;
      step_irq_o     <= 1'b0;
      sync_pulse_o   <= 1'b0;
      differential_o <= 1'b0;
      chan_o         <= '0;
      gain_o         <= '0;
      dir_o          <= 1'b0;
      subsys_o       <= '0;
      busy_o         <= 1'b0;
    end else if (ce_i) begin
      step_irq_o   <= step_end && ent.irq;
      irq_ff       <= irq_ff | (step_end && ent.irq);
      // one cycle per step, at its end, like the interrupt
      sync_pulse_o <= step_end && ent.sync;
      // settle too, so a no-wait step still shows its own fields
      if (state_ff == ST_WAIT || state_ff == ST_SETTLE) begin
        differential_o <= ent.diff;
        chan_o         <= ent.chan;
        gain_o         <= ent.gain;
        dir_o          <= ent.dir;
        subsys_o       <= MULTI_SS ? ent.ss : 2'b00;
      end
      busy_o <= state_ff != ST_IDLE;
    end
  end
endmodule : cls_sequencer
`default_nettype wire

// *** rtl/cls_pkg.sv ***
// cls_pkg: constants and carriers for the channel list sequencer
// assumes a single 100 MHz clock domain, apb register access
package cls_pkg;
  // =========================================================
  // entry field positions
  localparam int unsigned BIT_MORE     = 31;
  localparam int unsigned BIT_DIR      = 30;
  localparam int unsigned BIT_SS_LO    = 28;
  localparam int unsigned BIT_IRQ      = 27;
  localparam int unsigned BIT_NOWAIT   = 26;
  localparam int unsigned BIT_DISCARD  = 25;
  localparam int unsigned BIT_LISTWAIT = 24;
  localparam int unsigned BIT_SYNC     = 23;
  localparam int unsigned BIT_DEFER    = 22;
  localparam int unsigned BIT_COMMIT   = 21;
  localparam int unsigned BIT_TSTAMP   = 20;
  localparam int unsigned BIT_SLOW     = 19;
  localparam int unsigned BIT_DIFF     = 15;
  localparam int unsigned GAIN_LO      = 8;
  localparam logic [31:0] CHAN_MASK    = 32'h0000_00FF;
  localparam logic [31:0] GAIN_MASK    = 32'h0000_0F00;
  localparam int unsigned TS_WORDS     = 2;
  // =========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_ENTRY  = 8'h08;
  localparam logic [7:0] OFS_SETTLE = 8'h0C;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] OFS_TSTAMP = 8'h14;
  localparam logic [7:0] OFS_OUTVAL = 8'h18;
  // reset values
  localparam logic [15:0] SETTLE_RST = 16'h0004;
  // =========================================================
  // timing: one settle unit is 10 ns at 100 MHz
  localparam int unsigned CLK_MHZ   = 100;
  localparam int unsigned SETTLE_NS = 40;
  localparam int unsigned SETTLE_CY = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FETCH  = 3'b001,
    ST_WAIT   = 3'b011,
    ST_SETTLE = 3'b010,
    ST_STORE  = 3'b110,
    ST_TS     = 3'b111,
    ST_DONE   = 3'b101
  } cls_state_e;

  typedef struct packed {
    logic       more;
    logic       dir;
    logic [1:0] ss;
    logic       irq;
    logic       nowait;
    logic       discard;
    logic       listwait;
    logic       sync;
    logic       defer;
    logic       commit;
    logic       tstamp;
    logic       slow;
    logic       diff;
    logic [3:0] gain;
    logic [7:0] chan;
  } cls_entry_s;
endpackage : cls_pkg

// *** rtl/cls_fifo.sv ***
// cls_fifo: synchronous valid/ready fifo, width and depth parameters
// assumes same clock as its user; depth a power of two
`timescale 1ns/1ps
`default_nettype none
module cls_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             en_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wp_ff;
  logic [AW:0]      rp_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
  assign out_valid_o = wp_ff != rp_ff;
  assign out_data_o  = mem_ff[rp_ff[AW-1:0]];
  assign push        = en_i && in_valid_i && in_ready_o;
  assign pop         = en_i && out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop)  rp_ff <= rp_ff + 1'b1;
    end
  end
endmodule : cls_fifo
`default_nettype wire

// *** dv/cls_seq_properties.sv ***
// cls_seq_properties: concurrent checks on the sequencer ports
// assumes bind to cls_sequencer with ce_i held high by the bench
`timescale 1ns/1ps
`default_nettype none
module cls_seq_properties
  import cls_pkg::*;
#(
  parameter int unsigned NUM_OUT = 8
) (
  input wire logic                 clk_i,
  input wire logic                 nrst_i,
  input wire logic                 ce_i,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [7:0]           paddr,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 step_irq_o,
  input wire logic                 sync_pulse_o,
  input wire logic [NUM_OUT*16-1:0] out_o,
  input wire logic                 busy_o
);
  logic mapped;
  assign mapped = paddr inside {OFS_CTRL, OFS_STATUS, OFS_ENTRY, OFS_SETTLE,
                                OFS_DATA, OFS_TSTAMP, OFS_OUTVAL};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // =========================================================
  // bus handshake
  sequence setup_s; psel && !penable && ce_i; endsequence
  sequence access_s; psel && penable; endsequence
  AST_PREADY_NEXT: assert property (setup_s |=> pready)
    else $error("pready not one cycle after setup");
  AST_PREADY_ONE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_PREADY_ACCESS: assert property (pready |-> access_s)
    else $error("pready outside access phase");
  AST_SLVERR_MAP: assert property (pready |-> (pslverr == !mapped))
    else $error("slave error does not match address map");
  // =========================================================
  // step events
  AST_IRQ_PULSE: assert property (step_irq_o |=> !step_irq_o)
    else $error("step interrupt longer than one cycle");
  AST_IRQ_IN_RUN: assert property (step_irq_o |-> busy_o || $past(busy_o))
    else $error("step interrupt with no list running");
  AST_SYNC_PULSE: assert property (sync_pulse_o |=> !sync_pulse_o)
    else $error("sync pulse longer than one cycle");
  AST_OUT_IN_RUN: assert property (!$stable(out_o) |-> busy_o || $past(busy_o))
    else $error("outputs changed with no list running");
endmodule : cls_seq_properties
`default_nettype wire

// *** dv/cls_src_model.sv ***
// cls_src_model: far side, conversion and list ticks plus a sample value
// assumes the same clock as the sequencer
`timescale 1ns/1ps
`default_nettype none
module cls_src_model (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  output logic             conversion_clock_o,
  output logic             list_clock_o,
  output logic      [15:0] sample_o
);
  logic [7:0] cnt_ff;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;
  end
  // conversion tick every 16 cycles, list tick every 128
  assign conversion_clock_o = cnt_ff[3];
  assign list_clock_o       = cnt_ff[6];
  // constant so each stored sample word has a known value
  assign sample_o           = 16'hA5C3;
endmodule : cls_src_model
`default_nettype wire

// *** dv/cls_sequencer_tb.sv ***
// cls_sequencer_tb: apb driven tests of list decode, data and outputs
// assumes cls_src_model supplies ticks and samples
`timescale 1ns/1ps
`default_nettype none
module cls_sequencer_tb;
  import cls_pkg::*;
  localparam int unsigned NO = 4;
  logic clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, cv, cl;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] smp;
  logic [NO*16-1:0] out_o;
  logic busy_o, err, irq_o, sync_o, diff_o, dir_o;
  logic [7:0] chan_o;
  logic [3:0] gain_o;
  logic [1:0] subsys_o;
  logic [12:0] irq_seen;
  logic [31:0] ts [3];
  int n_fail, n_checks, cyc, n_irq, n_sync;
  cls_sequencer #(.NUM_OUT(NO)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
    .ce_i(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conversion_clock_i(cv), .list_clock_i(cl),
    .sample_i(smp), .step_irq_o(irq_o), .sync_pulse_o(sync_o),
    .differential_o(diff_o), .chan_o(chan_o), .gain_o(gain_o),
    .dir_o(dir_o), .subsys_o(subsys_o), .out_o(out_o),
    .busy_o(busy_o));
  cls_src_model u_src (.clk_i(clk_i), .nrst_i(nrst_i),
    .conversion_clock_o(cv), .list_clock_o(cl), .sample_o(smp));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // =========================================================
  // tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic run_list(input logic [31:0] e[]);
    apb(1'b1, OFS_CTRL, 32'h2);
    foreach (e[i]) apb(1'b1, OFS_ENTRY, e[i]);
    apb(1'b1, OFS_CTRL, 32'h1);
    repeat (4) @(posedge clk_i);
    // the bench-wide cycle ceiling ends a list that never stops
    while (busy_o !== 1'b0) @(posedge clk_i);
  endtask : run_list
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // step pulses and the fields that stand while they fire
  always @(posedge clk_i) begin
    if (irq_o === 1'b1) begin
      n_irq++;
      irq_seen <= {diff_o, gain_o, chan_o};
    end
    if (sync_o === 1'b1) n_sync++;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  // =========================================================
  // tests
  initial begin
    nrst_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; n_fail = 0; n_checks = 0; cyc = 0;
    n_irq = 0; n_sync = 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk(32'(busy_o), 32'h0, "busy after reset");
    apb(1'b0, OFS_SETTLE, 32'h0);
    chk(rd, 32'h4, "settle reset value");
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1, "unmapped read");
    $display("test registers done");
    // irq+sync+diff+reserved, discard, timestamp+slow last, never run
    run_list('{32'h8881_8512, 32'h8200_0034, 32'h0018_0056, 32'h0000_0078});
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h2, "irq seen, idle");
    chk(n_irq, 32'h1, "one step interrupt");
    chk(n_sync, 32'h1, "one sync pulse");
    chk(32'(irq_seen[12]), 32'h1, "differential step");
    chk(32'(irq_seen[11:0]), 32'h512, "gain and channel");
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(32'(rd[2]), 32'h1, "fifo word present");
      apb(1'b0, OFS_DATA, 32'h0);
      if (i == 0) chk(rd, 32'h0012_A5C3, "first word");
      if (i == 1) chk(rd, 32'h0056_A5C3, "discarded step stored");
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(32'(rd[2]), 32'h0, "extra fifo words");
    $display("test acquisition done");
    // no-wait step, plain step, step held for the list tick; all stamped
    run_list('{32'h8410_0021, 32'h8010_0022, 32'h0110_0023});
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, OFS_DATA, 32'h0);
      if (i % 3 == 0) begin
        chk(rd, 32'h0021_A5C3 + 32'((i / 3) << 16), "step data");
      end else if (i % 3 == 1) begin
        ts[i / 3] = rd;
      end else begin
        chk(rd, ts[i / 3] + 1, "timestamp pair");
      end
    end
    // conversion ticks come every 16 cycles, list ticks every 128
    rd = ts[1] - ts[0];
    chk(32'(rd < 32'h10), 32'h1, "no-wait step waited");
    rd = (ts[2] - 32'h40) % 32'h80;
    chk(32'(rd < 32'h10), 32'h1, "list tick wait");
    $display("test step timing done");
    apb(1'b1, OFS_OUTVAL, 32'h1234);
    // loader: deferred on outputs 1 and 2, commit on the last
    run_list('{32'h4040_0001});
    chk(32'(out_o[31:16]), 32'h0, "deferred write reached output");
    run_list('{32'h7060_0002});
    chk(32'(out_o[31:16]), 32'h1234, "held value not committed");
    chk(32'(out_o[47:32]), 32'h1234, "last value not committed");
    chk(32'(dir_o), 32'h1, "output direction");
    chk(32'(subsys_o), 32'h3, "subsystem number");
    $display("test outputs done");
    finish_test();
  end
endmodule : cls_sequencer_tb
bind cls_sequencer cls_seq_properties #(.NUM_OUT(NUM_OUT)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .step_irq_o(step_irq_o), .sync_pulse_o(sync_pulse_o), .out_o(out_o),
  .busy_o(busy_o));
`default_nettype wire
